// *** pcsr_bus_agent.sv ***
// Purpose : Behavioural stand-in for the bus interface and other bus agents
// Assumes : Happenings are reported as one-cycle pulses, changed at the falling edge
// Notes   : Drives all-zero between pulses so no stale event lingers
`timescale 1ns/10ps
module pcsr_bus_agent
  import pcsr_pkg::*;
(
  // Clock
  input  wire logic    i_clk,
  // Bus happenings toward the register block
  output pcsr_bus_evt_t o_bus
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  initial begin
    o_bus = '0; // Quiet bus until the bench asks for a happening
  end

  // ---------------------------------------------------------------
  // One happening, held for exactly one clock
  // ---------------------------------------------------------------
  // Error reporting from any agent, including PERR with mastership flag
  task automatic pulse(input pcsr_bus_evt_t evt);
    @(negedge i_clk);
    o_bus = evt;
    @(negedge i_clk);
    o_bus = '0; // Dropped after one edge, a longer level would double-count
  endtask
endmodule

// *** pcsr_config_regs.sv ***
// Purpose : Status, revision, class code and cache line size of a function's config header
// Assumes : Config reads and writes arrive as one-cycle strobes from the bus interface
// Notes   : Command register lives elsewhere; its enables arrive here as plain inputs
//
// Behaviour
// - Any detected parity error sets bit 15
// - Signalling SERR while enabled sets bit 14
// - Own cycle master aborted sets bit 13
// - Own cycle target aborted sets bit 12
// - Signalling a target abort sets bit 11
// - Bits 10:9 read 01, medium claim timing
// - Bit 8 needs PERR, mastership, parity enable
// - Writing one clears a flag, zero keeps
// - Parity response enable gates parity reaction
// - Address parity SERR needs both enables
// - Bit 7 reads zero, no fast back-to-back
// - Bit 6 reads zero, no user features
// - Bit 5 reads zero, not double speed
// - Bit 4 reads one, capability list present
// - Bits 3:0 read zero
// - Read-only 8-bit revision at 08h
// - Read-only class code 060700h at 09h
// - Cache line size read/write, resets 00h
`timescale 1ns/10ps
module pcsr_config_regs
  import pcsr_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Configuration access
  input  wire pcsr_cfg_req_t i_cfg,
  output logic [31:0]        o_cfg_rdata,
  output logic               o_cfg_ack,
  // Bus happenings and command enables
  input  wire pcsr_bus_evt_t i_bus,
  input  wire logic          i_parity_response_enable,
  input  wire logic          i_system_error_enable,
  // Bus-side outputs
  output logic               o_serr_drive,
  output logic               o_perr_drive,
  output logic [1:0]         o_devsel_timing,
  output logic [7:0]         o_cache_line_size
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pcsr_evt_t   evt;          // Qualified events, registered
  logic [15:0] set_vec;      // Events placed at their status positions
  logic [15:0] clr_vec;      // Ones written to the status halfword
  logic [15:0] status_w;     // Status as read
  logic [31:0] lane_mask;    // Byte enables as a bit mask
  logic [5:0]  dword;        // Dword being addressed
  logic        wr_status;    // Write hits the status dword
  logic        wr_cache;     // Write hits the cache line dword
  logic [7:0]  cls_q;        // Cache line size
  logic [7:0]  cls_d;
  logic [31:0] rdata_q;      // Read data held for the bus
  logic [31:0] rdata_d;
  logic        ack_q;        // Read or write acknowledge
  logic        ack_d;
  logic [1:0]  devsel_q;     // Claim timing reported to the bus interface
  logic [1:0]  devsel_d;

  // ---------------------------------------------------------------
  // Error qualification
  // ---------------------------------------------------------------
  // Qualifying here keeps the enable gating in one place for pins and flags
  pcsr_err_respond u_err (
    .i_clk                    (i_clk),
    .i_rst                    (i_rst),
    .i_bus                    (i_bus),
    .i_parity_response_enable (i_parity_response_enable),
    .i_system_error_enable    (i_system_error_enable),
    .o_evt                    (evt),
    .o_serr_drive             (o_serr_drive),
    .o_perr_drive             (o_perr_drive)
  );

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  // Place events and clears at their bit positions
  always_comb begin
    lane_mask = pcsr_lane_mask(i_cfg.be);
    dword     = i_cfg.addr[7:2];
    wr_status = i_cfg.wr && (dword == pcsr_dword(PCSR_STATUS_OFS));
    wr_cache  = i_cfg.wr && (dword == pcsr_dword(PCSR_CACHE_LINE_OFS));
    set_vec   = '0;
    set_vec[PCSR_PARITY_DET_BIT]   = evt.parity_det;
    set_vec[PCSR_SYSTEM_ERR_BIT]   = evt.system_err;
    set_vec[PCSR_MASTER_ABORT_BIT] = evt.master_abort;
    set_vec[PCSR_TGT_ABORT_RX_BIT] = evt.tabt_rx;
    set_vec[PCSR_TGT_ABORT_TX_BIT] = evt.tabt_tx;
    set_vec[PCSR_MASTER_DPE_BIT]   = evt.data_par;
    // Status sits in the upper halfword; disabled lanes clear nothing
    clr_vec   = '0;
    if (wr_status) begin
      clr_vec = i_cfg.wdata[31:16] & lane_mask[31:16] & PCSR_STATUS_CLEARABLE;
    end
  end

  // ---------------------------------------------------------------
  // Status bits
  // ---------------------------------------------------------------
  // Clearable bits get a flag each; the rest are tied to their fixed values
  for (genvar g = 0; g < 16; g++) begin : g_status
    if (PCSR_STATUS_CLEARABLE[g]) begin : g_flag
      pcsr_sticky_bit u_flag (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_set  (set_vec[g]),
        .i_clr  (clr_vec[g]),
        .o_flag (status_w[g])
      );
    end else begin : g_fixed
      // Hardwired, writes cannot reach these
      assign status_w[g] = PCSR_STATUS_FIXED[g];
    end
  end

  // ---------------------------------------------------------------
  // Cache line size, read data, claim timing
  // ---------------------------------------------------------------
  // Next values for the registers of this block
  always_comb begin
    cls_d = cls_q;
    if (wr_cache && i_cfg.be[0]) begin
      cls_d = i_cfg.wdata[7:0];
    end
    ack_d    = i_cfg.wr | i_cfg.rd;
    rdata_d  = rdata_q;
    devsel_d = status_w[PCSR_DEVSEL_LO_BIT +: 2];
    if (i_cfg.rd) begin
      if (dword == pcsr_dword(PCSR_CMD_STATUS_OFS)) begin
        // Command halfword is served by its own block, reads zero here
        rdata_d = {status_w, 16'h0000};
      end else if (dword == pcsr_dword(PCSR_REVISION_OFS)) begin
        // Both fields are constants, so writes here are dropped
        rdata_d = {PCSR_CLASS_CODE, PCSR_REVISION};
      end else if (dword == pcsr_dword(PCSR_CACHE_LINE_OFS)) begin
        // Neighbouring bytes of this dword belong to other blocks
        rdata_d = {24'h000000, cls_q};
      end else begin
        // Unmapped dwords read zero
        rdata_d = 32'h00000000;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cls_q    <= PCSR_CACHE_LINE_RESET;
      rdata_q  <= 32'h00000000;
      ack_q    <= 1'b0;
      devsel_q <= PCSR_DEVSEL_MEDIUM;
    end else begin
      cls_q    <= cls_d;
      rdata_q  <= rdata_d;
      ack_q    <= ack_d;
      devsel_q <= devsel_d;
    end
  end

  assign o_cfg_rdata       = rdata_q;
  assign o_cfg_ack         = ack_q;
  assign o_devsel_timing   = devsel_q;
  assign o_cache_line_size = cls_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Address parity with both enables, then SERR, then the flag
  sequence s_addr_par_reported;
    i_bus.addr_par && i_system_error_enable && i_parity_response_enable;
  endsequence

  sequence s_serr_then_flag;
    o_serr_drive ##1 status_w[PCSR_SYSTEM_ERR_BIT];
  endsequence

  // One written to bit 15 with no new parity event
  sequence s_par_clear;
    wr_status && i_cfg.be[3] && i_cfg.wdata[31] && !set_vec[PCSR_PARITY_DET_BIT];
  endsequence

  // Status read issued
  sequence s_status_read;
    i_cfg.rd && (dword == pcsr_dword(PCSR_CMD_STATUS_OFS));
  endsequence

  AST_PARITY_DET_SET: assert property (
    (i_bus.addr_par || i_bus.data_par) |-> ##2 status_w[PCSR_PARITY_DET_BIT])
    else $error("parity error did not set status bit 15");

  AST_SYSTEM_ERR_SET: assert property (
    s_addr_par_reported |-> ##1 s_serr_then_flag)
    else $error("reported address parity did not raise SERR and bit 14");

  AST_SERR_GATED: assert property (
    o_serr_drive |-> $past(i_bus.addr_par && i_system_error_enable && i_parity_response_enable))
    else $error("SERR driven without address parity and both enables");

  AST_MASTER_ABORT_SET: assert property (
    i_bus.master_abort |-> ##2 status_w[PCSR_MASTER_ABORT_BIT])
    else $error("master abort did not set status bit 13");

  AST_TGT_ABORT_RX_SET: assert property (
    i_bus.tabt_rx |-> ##2 status_w[PCSR_TGT_ABORT_RX_BIT])
    else $error("received target abort did not set status bit 12");

  AST_TGT_ABORT_TX_SET: assert property (
    i_bus.tabt_tx |-> ##2 status_w[PCSR_TGT_ABORT_TX_BIT])
    else $error("signalled target abort did not set status bit 11");

  AST_MASTER_DPE_COND: assert property (
    $rose(status_w[PCSR_MASTER_DPE_BIT])
      |-> $past(i_bus.perr_seen && i_bus.master_phase && i_parity_response_enable, 2))
    else $error("bit 8 set without all three conditions");

  AST_PERR_GATED: assert property (
    (i_bus.data_par && !i_parity_response_enable) |=> !o_perr_drive)
    else $error("PERR driven while parity response disabled");

  AST_W1C_CLEARS: assert property (
    s_par_clear |=> !status_w[PCSR_PARITY_DET_BIT])
    else $error("writing one did not clear status bit 15");

  AST_FIXED_READ: assert property (
    s_status_read |=> o_cfg_ack && ((o_cfg_rdata[31:16] & ~PCSR_STATUS_CLEARABLE) == PCSR_STATUS_FIXED))
    else $error("fixed status bits read back wrong");

  AST_CLASS_READ: assert property (
    (i_cfg.rd && (dword == pcsr_dword(PCSR_REVISION_OFS)))
      |=> (o_cfg_rdata == {PCSR_CLASS_CODE, PCSR_REVISION}))
    else $error("revision and class dword read back wrong");

  AST_CLS_WRITE: assert property (
    (wr_cache && i_cfg.be[0]) |=> (o_cache_line_size == $past(i_cfg.wdata[7:0])))
    else $error("cache line size write not taken");

  AST_DEVSEL_MEDIUM: assert property (
    ##1 (o_devsel_timing == PCSR_DEVSEL_MEDIUM))
    else $error("claim timing is not medium");

  // Master data phase with PERR seen and parity response on
  sequence s_master_perr;
    i_bus.perr_seen && i_bus.master_phase && i_parity_response_enable;
  endsequence

  AST_MASTER_DPE_SET: assert property (
    s_master_perr |-> ##2 status_w[PCSR_MASTER_DPE_BIT])
    else $error("master data parity did not set bit 8");

  AST_PERR_DRIVEN: assert property (
    (i_bus.data_par && i_parity_response_enable) |=> o_perr_drive)
    else $error("data parity with response on did not drive PERR");

  // A flag stays up until a one is written to it
  AST_FLAG_HOLDS: assert property (
    (status_w[PCSR_PARITY_DET_BIT] && !clr_vec[PCSR_PARITY_DET_BIT]) |=> status_w[PCSR_PARITY_DET_BIT])
    else $error("bit 15 dropped without a clear");

  AST_ZERO_KEEPS: assert property (
    (wr_status && i_cfg.be[3] && !i_cfg.wdata[29] && status_w[PCSR_MASTER_ABORT_BIT])
      |=> status_w[PCSR_MASTER_ABORT_BIT])
    else $error("writing zero cleared bit 13");

  // An event in the clearing cycle must not be lost
  AST_SET_WINS: assert property (
    (set_vec[PCSR_MASTER_ABORT_BIT] && clr_vec[PCSR_MASTER_ABORT_BIT]) |=> status_w[PCSR_MASTER_ABORT_BIT])
    else $error("same-cycle event lost to a clear");

  AST_RSVD_READ: assert property (
    s_status_read |=> (o_cfg_rdata[19:16] == 4'h0))
    else $error("reserved status bits read nonzero");

  AST_NO_FAST_B2B: assert property (
    s_status_read |=> !o_cfg_rdata[16 + PCSR_FBB_BIT])
    else $error("fast back-to-back bit reads one");

  AST_NO_USER_FEAT: assert property (
    s_status_read |=> !o_cfg_rdata[16 + PCSR_USER_FEAT_BIT])
    else $error("user feature bit reads one");

  AST_NOT_DBL_SPEED: assert property (
    s_status_read |=> !o_cfg_rdata[16 + PCSR_DBL_SPEED_BIT])
    else $error("double speed bit reads one");

  AST_CAP_LIST_READ: assert property (
    s_status_read |=> o_cfg_rdata[16 + PCSR_CAP_LIST_BIT])
    else $error("capability list bit reads zero");

  // Read returns the value held before any same-cycle write
  AST_CLS_READ: assert property (
    (i_cfg.rd && (dword == pcsr_dword(PCSR_CACHE_LINE_OFS)))
      |=> (o_cfg_rdata == {24'h000000, $past(o_cache_line_size)}))
    else $error("cache line size read back wrong");

  // First edge out of reset sees the defaults
  AST_RESET_VALUES: assert property (
    $fell(i_rst) |-> (o_cache_line_size == PCSR_CACHE_LINE_RESET) && (status_w == PCSR_STATUS_FIXED))
    else $error("values after reset wrong");

endmodule

// *** pcsr_config_regs_tb.sv ***
// Purpose : Self-checking bench for the config status, revision, class and cache line registers
// Assumes : Strobes and happenings change at the falling edge, answers one cycle later
// Notes   : Flags are cleared after every happening so each check starts from 0210h
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
  end \
end
module pcsr_config_regs_tb;
  import pcsr_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic          i_clk = 1'b0; // Bus clock, 40 MHz
  logic          i_rst = 1'b1; // Synchronous reset
  pcsr_cfg_req_t cfg   = '0;   // Config access request
  pcsr_bus_evt_t bus;          // Happenings from the agent model
  logic          pe    = 1'b0; // Parity response enable
  logic          se    = 1'b0; // System error enable
  logic [31:0]   o_cfg_rdata;  // Read data
  logic          o_cfg_ack;    // Access answer
  logic          o_serr_drive; // SERR request
  logic          o_perr_drive; // PERR request
  logic [1:0]    o_devsel_timing;
  logic [7:0]    o_cache_line_size;
  int            errors    = 0;
  int            tests_run = 0;
  logic [31:0]   d;            // Last read data

  always #12.5 i_clk = ~i_clk;

  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  pcsr_config_regs i_dut (
    .i_clk                    (i_clk),
    .i_rst                    (i_rst),
    .i_cfg                    (cfg),
    .o_cfg_rdata              (o_cfg_rdata),
    .o_cfg_ack                (o_cfg_ack),
    .i_bus                    (bus),
    .i_parity_response_enable (pe),
    .i_system_error_enable    (se),
    .o_serr_drive             (o_serr_drive),
    .o_perr_drive             (o_perr_drive),
    .o_devsel_timing          (o_devsel_timing),
    .o_cache_line_size        (o_cache_line_size)
  );
  pcsr_bus_agent i_agent (
    .i_clk (i_clk),
    .o_bus (bus)
  );

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  // Read one dword; ack and data are taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(negedge i_clk);
    cfg.rd   = 1'b1;
    cfg.addr = a;
    @(negedge i_clk);
    cfg.rd = 1'b0;
    `CHK(o_cfg_ack, 1'b1)
    q = o_cfg_rdata;
  endtask

  // Write one dword with byte enables
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w);
    @(negedge i_clk);
    cfg.wr    = 1'b1;
    cfg.addr  = a;
    cfg.be    = be;
    cfg.wdata = w;
    @(negedge i_clk);
    cfg.wr = 1'b0;
    `CHK(o_cfg_ack, 1'b1)
  endtask

  // One happening: check pin requests, recorded status, then clear by ones
  task automatic run_evt(input logic [6:0] ev, input logic pe_v, input logic se_v,
                         input logic [15:0] st, input logic serr, input logic perr);
    pe = pe_v;
    se = se_v;
    i_agent.pulse(pcsr_bus_evt_t'(ev));
    `CHK(o_serr_drive, serr)
    `CHK(o_perr_drive, perr)
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, {st, 16'h0000})
    wr(PCSR_CMD_STATUS_OFS, 4'b1100, 32'hffff_0000);
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h0210_0000)
  endtask

  // Counts, then the verdict; the only place the run ends
  task automatic give_verdict();
    $display("TB: %0d mismatches in %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Watchdog, about 25 times the expected run
  // ---------------------------------------------------------------
  initial begin
    #100000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    // Values after reset
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h0210_0000)
    `CHK(o_devsel_timing, 2'b01)
    rd(PCSR_REVISION_OFS, d);
    `CHK(d, {24'h060700, PCSR_REVISION})
    rd(PCSR_CACHE_LINE_OFS, d);
    `CHK(d, 32'h0000_0000)
    rd(8'h40, d);
    `CHK(d, 32'h0000_0000)
    // Writes of ones to fixed bits change nothing
    wr(PCSR_REVISION_OFS, 4'hf, 32'hffff_ffff);
    rd(PCSR_REVISION_OFS, d);
    `CHK(d, {24'h060700, PCSR_REVISION})
    wr(PCSR_CMD_STATUS_OFS, 4'hf, 32'hffff_ffff);
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h0210_0000)
    // Cache line size, lane 0 only
    wr(PCSR_CACHE_LINE_OFS, 4'b0001, 32'hffff_ffa5);
    `CHK(o_cache_line_size, 8'ha5)
    wr(PCSR_CACHE_LINE_OFS, 4'b1110, 32'hffff_ff00);
    rd(PCSR_CACHE_LINE_OFS, d);
    `CHK(d, 32'h0000_00a5)
    // Every happening under the enable settings that matter
    run_evt(7'h40, 1'b1, 1'b1, 16'hc210, 1'b1, 1'b0);
    run_evt(7'h40, 1'b1, 1'b0, 16'h8210, 1'b0, 1'b0);
    run_evt(7'h40, 1'b0, 1'b1, 16'h8210, 1'b0, 1'b0);
    run_evt(7'h20, 1'b1, 1'b0, 16'h8210, 1'b0, 1'b1);
    run_evt(7'h20, 1'b0, 1'b1, 16'h8210, 1'b0, 1'b0);
    run_evt(7'h38, 1'b1, 1'b0, 16'h8310, 1'b0, 1'b1);
    run_evt(7'h18, 1'b1, 1'b0, 16'h0310, 1'b0, 1'b0);
    run_evt(7'h18, 1'b0, 1'b1, 16'h0210, 1'b0, 1'b0);
    run_evt(7'h10, 1'b1, 1'b0, 16'h0210, 1'b0, 1'b0);
    run_evt(7'h08, 1'b1, 1'b0, 16'h0210, 1'b0, 1'b0);
    run_evt(7'h04, 1'b0, 1'b0, 16'h2210, 1'b0, 1'b0);
    run_evt(7'h02, 1'b0, 1'b0, 16'h1210, 1'b0, 1'b0);
    run_evt(7'h01, 1'b0, 1'b0, 16'h0a10, 1'b0, 1'b0);
    // An event meeting its own clear is kept; clearing respects lanes and ignores zeros
    fork
      i_agent.pulse(pcsr_bus_evt_t'(7'h04));
      begin
        @(negedge i_clk);
        wr(PCSR_STATUS_OFS, 4'b1000, 32'h2000_0000);
      end
    join
    wr(PCSR_CMD_STATUS_OFS, 4'b0100, 32'hffff_ffff);
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h2210_0000)
    wr(PCSR_STATUS_OFS, 4'b1100, 32'h0000_0000);
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h2210_0000)
    wr(PCSR_STATUS_OFS, 4'b1000, 32'h2000_0000);
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h0210_0000)
    // Reset in mid-run restores cache line size and drops an event not yet flagged
    i_agent.pulse(pcsr_bus_evt_t'(7'h01));
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    `CHK(o_cache_line_size, 8'h00)
    rd(PCSR_CMD_STATUS_OFS, d);
    `CHK(d, 32'h0210_0000)
    give_verdict();
  end
endmodule

// *** pcsr_err_respond.sv ***
// Purpose : Qualify raw bus happenings into status events and error pin requests
// Assumes : Bus happenings arrive as single-cycle pulses from the bus interface
// Notes   : All outputs are registered, one cycle behind their cause
`timescale 1ns/10ps
module pcsr_err_respond
  import pcsr_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Bus happenings and command enables
  input  wire pcsr_bus_evt_t i_bus,
  input  wire logic          i_parity_response_enable,
  input  wire logic          i_system_error_enable,
  // Qualified results
  output pcsr_evt_t          o_evt,
  output logic               o_serr_drive,
  output logic               o_perr_drive
);

  pcsr_evt_t evt_q;
  pcsr_evt_t evt_d;
  logic      serr_q;
  logic      serr_d;
  logic      perr_q;
  logic      perr_d;

  // Qualification of each happening
  always_comb begin
    // Address parity goes out on SERR only with both enables set
    serr_d            = i_bus.addr_par & i_system_error_enable & i_parity_response_enable;
    // Data parity is answered on PERR only when parity response is on
    perr_d            = i_bus.data_par & i_parity_response_enable;
    evt_d.parity_det  = i_bus.addr_par | i_bus.data_par;
    evt_d.system_err  = serr_d;
    evt_d.master_abort = i_bus.master_abort;
    evt_d.tabt_rx     = i_bus.tabt_rx;
    evt_d.tabt_tx     = i_bus.tabt_tx;
    // All three conditions must meet in the same data phase
    evt_d.data_par    = i_bus.perr_seen & i_bus.master_phase & i_parity_response_enable;
  end

  // Result registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_q  <= '0;
      serr_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      evt_q  <= evt_d;
      serr_q <= serr_d;
      perr_q <= perr_d;
    end
  end

  assign o_evt        = evt_q;
  assign o_serr_drive = serr_q;
  assign o_perr_drive = perr_q;

endmodule

// *** pcsr_pkg.sv ***
// Purpose : Shared constants and carrier types for the config status and ID registers
// Assumes : Byte offsets within a function's configuration header, dword accesses with byte enables
// Notes   : Every offset, field position, reset value and fixed value lives here only
package pcsr_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses in configuration space)
  // ---------------------------------------------------------------
  localparam logic [7:0]  PCSR_CMD_STATUS_OFS  = 8'h04; // Dword holding command (low) and status (high)
  localparam logic [7:0]  PCSR_STATUS_OFS      = 8'h06; // Status register, byte lanes 2 and 3
  localparam logic [7:0]  PCSR_REVISION_OFS    = 8'h08; // Silicon revision, byte lane 0
  localparam logic [7:0]  PCSR_CLASS_OFS       = 8'h09; // Class code, byte lanes 1 to 3
  localparam logic [7:0]  PCSR_CACHE_LINE_OFS  = 8'h0c; // Cache line size, byte lane 0

  // ---------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------
  localparam int          PCSR_PARITY_DET_BIT   = 15; // parity_error_detected
  localparam int          PCSR_SYSTEM_ERR_BIT   = 14; // system_error_signalled
  localparam int          PCSR_MASTER_ABORT_BIT = 13; // master_abort_received
  localparam int          PCSR_TGT_ABORT_RX_BIT = 12; // target_abort_received
  localparam int          PCSR_TGT_ABORT_TX_BIT = 11; // target_abort_signalled
  localparam int          PCSR_DEVSEL_LO_BIT    = 9;  // Low bit of the two-bit timing field
  localparam int          PCSR_MASTER_DPE_BIT   = 8;  // master_data_parity_error
  localparam int          PCSR_FBB_BIT          = 7;  // fast_b2b_capable
  localparam int          PCSR_USER_FEAT_BIT    = 6;  // user_feature_support
  localparam int          PCSR_DBL_SPEED_BIT    = 5;  // double_speed_capable
  localparam int          PCSR_CAP_LIST_BIT     = 4;  // capability_list_present

  // ---------------------------------------------------------------
  // Fixed and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  PCSR_DEVSEL_MEDIUM   = 2'h1;      // Medium claim timing
  localparam logic [15:0] PCSR_STATUS_FIXED    = 16'h0210;  // Hardwired bits, also the reset value
  localparam logic [15:0] PCSR_STATUS_CLEARABLE = 16'hf900; // Bits that record events
  localparam logic        PCSR_FLAG_RESET      = 1'b0;      // Event flags start clear
  localparam logic [7:0]  PCSR_REVISION        = 8'h3c;     // Arbitrary value, not a real part's
  localparam logic [23:0] PCSR_CLASS_CODE      = 24'h060700; // Bridge, CardBus bridge, interface 00
  localparam logic [7:0]  PCSR_CACHE_LINE_RESET = 8'h00;    // Cache line size after reset

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  // Configuration access from the bus interface
  typedef struct packed {
    logic        wr;    // One-cycle write strobe
    logic        rd;    // One-cycle read strobe
    logic [7:0]  addr;  // Byte address, low two bits ignored
    logic [3:0]  be;    // Byte enables, high active
    logic [31:0] wdata; // Write data
  } pcsr_cfg_req_t;

  // Raw bus happenings reported by the bus interface, one-cycle pulses
  typedef struct packed {
    logic addr_par;     // Address parity error seen
    logic data_par;     // Data parity error seen
    logic perr_seen;    // PERR observed on the bus, from any agent
    logic master_phase; // This function is master for the current data phase
    logic master_abort; // Own cycle ended by master abort
    logic tabt_rx;      // Own cycle ended by a target abort
    logic tabt_tx;      // This function ended a cycle with a target abort
  } pcsr_bus_evt_t;

  // Qualified events that set the status flags
  typedef struct packed {
    logic parity_det;
    logic system_err;
    logic master_abort;
    logic tabt_rx;
    logic tabt_tx;
    logic data_par;
  } pcsr_evt_t;

  // Dword index of a byte offset
  function automatic logic [5:0] pcsr_dword(input logic [7:0] ofs);
    return ofs[7:2];
  endfunction

  // Byte enables widened to a 32-bit mask
  function automatic logic [31:0] pcsr_lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// *** pcsr_sticky_bit.sv ***
// Purpose : One write-one-to-clear event flag
// Assumes : Set and clear are single-cycle strobes in the bus clock domain
// Notes   : A set in the clearing cycle wins, so no event is lost
`timescale 1ns/10ps
module pcsr_sticky_bit
  import pcsr_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Event and clear strobes
  input  wire logic i_set,
  input  wire logic i_clr,
  // Recorded flag
  output logic      o_flag
);

  logic flag_q; // Recorded event
  logic flag_d; // Next value

  // Clear first, then let a new event override it
  always_comb begin
    flag_d = flag_q;
    if (i_clr) begin
      flag_d = 1'b0;
    end
    if (i_set) begin
      flag_d = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_q <= PCSR_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule
